// *** core/gpio_port.sv ***
// eight-line general-purpose port with strap capture and interrupts
//
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "gpio_cfg.svh"

// Overview of operation
// - eight general-purpose lines, each on its own dedicated pin, which is also sampled into the strap register at reset.
// - the eight lines are gathered into one 8-bit data register, one bit per line.
// - each line is made input or output on its own by its bit in the direction register.
// - reset sets every line to input, so no pin is driven until software changes direction.
// - pin levels are caught into a strap register at reset and kept for software to read.
// - lines set as input can raise an interrupt, output lines raise nothing, and each line's source can be masked individually.
module gpio_port
   import gpio_pkg::*;
(
   input  wire logic              sys_clk,
   input  wire logic              rst_n,
   input  wire gpio_pkg::gpio_req_t req,
   output      logic [7:0]        rdata,
   input  wire logic [7:0]        pin_in,
   output      logic [7:0]        pin_out,
   output      logic [7:0]        pin_oe,
   output      logic              irq
);
   import gpio_pkg::*;

   // ==========================================================
   // state
   gpio_state_t state_r,  state_nxt;
   gpio_byte_t  sync1_r,  sync1_nxt;
   gpio_byte_t  sync2_r,  sync2_nxt;
   gpio_byte_t  prev_r,   prev_nxt;
   gpio_byte_t  strap_r,  strap_nxt;
   gpio_byte_t  data_r,   data_nxt;
   gpio_byte_t  dir_r,    dir_nxt;
   gpio_byte_t  mask_r,   mask_nxt;
   gpio_byte_t  edge_r,   edge_nxt;
   gpio_byte_t  pol_r,    pol_nxt;
   gpio_byte_t  status_r, status_nxt;
   gpio_byte_t  rdata_r,  rdata_nxt;
   gpio_drive_t drv_r,    drv_nxt;
   logic        irq_r,    irq_nxt;
   // events and write-one-to-clear bits of this cycle
   gpio_byte_t  ev;
   gpio_byte_t  clr;

   // ==========================================================
   // helpers
   // register select by offset
   function automatic logic hit(
      input logic [3:0] a,
      input logic [3:0] ofs
   );
      hit = (a == ofs);
   endfunction

   // writes are dropped during the strap phase
   function automatic logic wr_hit(
      input gpio_req_t   r,
      input gpio_state_t s,
      input logic [3:0]  ofs
   );
      wr_hit = r.wr && (s == ST_RUN) && hit(r.addr, ofs);
   endfunction

   // write data on a hit, else hold
   function automatic gpio_byte_t load(
      input logic       sel,
      input gpio_byte_t cur,
      input gpio_byte_t wd
   );
      load = sel ? wd : cur;
   endfunction

   // output lines show their data bit, input lines the synchronised pin
   function automatic gpio_byte_t mix(
      input gpio_byte_t drive,
      input gpio_byte_t pin,
      input gpio_byte_t dir
   );
      mix = (drive & dir) | (pin & ~dir);
   endfunction

   // level, or rising edge of the polarity-corrected level
   function automatic logic line_event(
      input logic cur_pin,
      input logic old_pin,
      input logic edge_mode,
      input logic low_act
   );
      logic lvl_cur;
      logic lvl_old;
      lvl_cur    = cur_pin ^ low_act;
      lvl_old    = old_pin ^ low_act;
      line_event = edge_mode ? (lvl_cur & ~lvl_old) : lvl_cur;
   endfunction

   // ==========================================================
   // strap phase
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_STRAP: state_nxt = ST_RUN;
         ST_RUN:   state_nxt = ST_RUN;
         default:  state_nxt = ST_STRAP;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         state_r <= ST_STRAP;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ==========================================================
   // pin synchroniser
   // no reset: stages follow the pins through reset, so release brings no false edge
   always_comb begin
      sync1_nxt = pin_in;
      sync2_nxt = sync1_r;
      prev_nxt  = sync2_r;
   end

   always_ff @(posedge sys_clk) begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
      prev_r  <= prev_nxt;
   end

   // ==========================================================
   // strap capture
   // taken on every reset edge; reset must last two edges so the pins are released first
   always_comb begin
      strap_nxt = strap_r;
      if (!rst_n) begin
         strap_nxt = pin_in;
      end
   end

   always_ff @(posedge sys_clk) begin
      strap_r <= strap_nxt;
   end

   // ==========================================================
   // data register
   always_comb begin
      data_nxt = load(wr_hit(req, state_r, `GPIO_OFS_DATA), data_r, req.wdata);
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         data_r <= `GPIO_RST_DATA;
      end else begin
         data_r <= data_nxt;
      end
   end

   // ==========================================================
   // direction register
   always_comb begin
      dir_nxt = load(wr_hit(req, state_r, `GPIO_OFS_DIR), dir_r, req.wdata);
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         dir_r <= `GPIO_RST_DIR;
      end else begin
         dir_r <= dir_nxt;
      end
   end

   // ==========================================================
   // mask register
   always_comb begin
      mask_nxt = load(wr_hit(req, state_r, `GPIO_OFS_MASK), mask_r, req.wdata);
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         mask_r <= `GPIO_RST_MASK;
      end else begin
         mask_r <= mask_nxt;
      end
   end

   // ==========================================================
   // edge mode register
   always_comb begin
      edge_nxt = load(wr_hit(req, state_r, `GPIO_OFS_EDGE), edge_r, req.wdata);
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         edge_r <= `GPIO_RST_EDGE;
      end else begin
         edge_r <= edge_nxt;
      end
   end

   // ==========================================================
   // polarity register
   always_comb begin
      pol_nxt = load(wr_hit(req, state_r, `GPIO_OFS_POL), pol_r, req.wdata);
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         pol_r <= `GPIO_RST_POL;
      end else begin
         pol_r <= pol_nxt;
      end
   end

   // ==========================================================
   // interrupt status
   always_comb begin
      ev  = 8'h00;
      clr = 8'h00;
      if (wr_hit(req, state_r, `GPIO_OFS_STATUS)) begin
         clr = req.wdata;
      end
      if (state_r == ST_RUN) begin
         for (int i = 0; i < `GPIO_WIDTH; i++) begin
            ev[i] = line_event(sync2_r[i], prev_r[i], edge_r[i], pol_r[i]);
         end
      end
      // output lines raise nothing; set wins over a same-cycle clear
      status_nxt = (status_r & ~clr) | (ev & ~dir_r);
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         status_r <= `GPIO_RST_STATUS;
      end else begin
         status_r <= status_nxt;
      end
   end

   // ==========================================================
   // read path
   // data stands one cycle after the strobe, zero otherwise
   always_comb begin
      rdata_nxt = 8'h00;
      if (req.rd) begin
         case (req.addr)
            `GPIO_OFS_DATA:   rdata_nxt = mix(data_r, sync2_r, dir_r);
            `GPIO_OFS_DIR:    rdata_nxt = dir_r;
            `GPIO_OFS_STRAP:  rdata_nxt = strap_r;
            `GPIO_OFS_STATUS: rdata_nxt = status_r;
            `GPIO_OFS_MASK:   rdata_nxt = mask_r;
            `GPIO_OFS_EDGE:   rdata_nxt = edge_r;
            `GPIO_OFS_POL:    rdata_nxt = pol_r;
            default:          rdata_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         rdata_r <= 8'h00;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   // ==========================================================
   // pin drive
   // built from next values so pins move at the write edge
   always_comb begin
      drv_nxt.out = data_nxt;
      drv_nxt.oe  = dir_nxt;
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         drv_r <= 16'h0000;
      end else begin
         drv_r <= drv_nxt;
      end
   end

   // ==========================================================
   // interrupt line
   always_comb begin
      irq_nxt = |(status_nxt & mask_nxt);
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= irq_nxt;
      end
   end

   // ==========================================================
   // outputs
   // every output straight from a flop
   assign rdata   = rdata_r;
   assign pin_out = drv_r.out;
   assign pin_oe  = drv_r.oe;
   assign irq     = irq_r;
endmodule // gpio_port

// *** core/gpio_cfg.svh ***
// register offsets, reset values and field widths of the gpio port
`ifndef GPIO_CFG_SVH
`define GPIO_CFG_SVH
`define GPIO_WIDTH       8
`define GPIO_ADDR_W      4
`define GPIO_OFS_DATA    4'h0
`define GPIO_OFS_DIR     4'h1
`define GPIO_OFS_STRAP   4'h2
`define GPIO_OFS_STATUS  4'h3
`define GPIO_OFS_MASK    4'h4
`define GPIO_OFS_EDGE    4'h5
`define GPIO_OFS_POL     4'h6
`define GPIO_RST_DATA    8'h00
`define GPIO_RST_DIR     8'h00
`define GPIO_RST_MASK    8'h00
`define GPIO_RST_EDGE    8'h00
`define GPIO_RST_POL     8'h00
`define GPIO_RST_STATUS  8'h00
`endif

// *** core/gpio_pkg.sv ***
// types shared by the gpio port
package gpio_pkg;
   typedef logic [7:0] gpio_byte_t;
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [3:0] addr;
      logic [7:0] wdata;
   } gpio_req_t;
   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
   } gpio_drive_t;
   typedef enum logic [1:0] {
      ST_STRAP = 2'b01,
      ST_RUN   = 2'b10
   } gpio_state_t;
endpackage

// *** tb/gpio_port_checker.sv ***
// pin and bus assertions for the gpio port
`timescale 1ns/1ps
module gpio_port_checker
   import gpio_pkg::*;
(
   input wire logic                sys_clk,
   input wire logic                rst_n,
   input wire gpio_pkg::gpio_req_t req,
   input wire logic [7:0]          rdata,
   input wire logic [7:0]          pin_in,
   input wire logic [7:0]          pin_out,
   input wire logic [7:0]          pin_oe,
   input wire logic                irq
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   a_oe_after_reset: assert property ($past(!rst_n) |-> pin_oe == 8'h00) else $error("oe after reset");
   a_dir_write: assert property ($past(rst_n) && req.wr && req.addr == 4'h1
      |=> pin_oe == $past(req.wdata)) else $error("dir write lost");
   a_data_write: assert property ($past(rst_n) && req.wr && req.addr == 4'h0
      |=> pin_out == $past(req.wdata)) else $error("data write lost");
   a_rdata_idle: assert property (!$past(req.rd) |-> rdata == 8'h00) else $error("rdata not idle");
   a_out_hold: assert property (!$past(req.wr) |-> $stable(pin_out)) else $error("pin out moved");
   a_oe_hold: assert property (!$past(req.wr) |-> $stable(pin_oe)) else $error("pin oe moved");
   a_mask_off: assert property ($past(rst_n) && req.wr && req.addr == 4'h4 && req.wdata == 8'h00
      |=> !irq) else $error("irq with mask off");
   a_out_read: assert property (req.rd && req.addr == 4'h0 && pin_oe == 8'hff
      |=> rdata == $past(pin_out)) else $error("output read wrong");
endmodule // gpio_port_checker

bind gpio_port gpio_port_checker i_chk (.sys_clk(sys_clk), .rst_n(rst_n), .req(req), .rdata(rdata),
   .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq));

// *** tb/gpio_board.sv ***
// board side: strap pulls and pin loop-back
`timescale 1ns/1ps
module gpio_board (
   input  wire logic [7:0] pin_out,
   input  wire logic [7:0] pin_oe,
   input  wire logic [7:0] pulls,
   output      logic [7:0] pin_in
);
   // an undriven pin falls to its pull level
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & pulls);
endmodule // gpio_board

// *** tb/tb_gpio_port.sv ***
// self-checking bench for the gpio port
`timescale 1ns/1ps
module tb_gpio_port;
   import gpio_pkg::*;
   logic       sys_clk = 1'b0;
   logic       rst_n = 1'b0;
   gpio_req_t  req = '0;
   logic [7:0] pulls = 8'h3c;
   logic [7:0] rdata, pin_in, pin_out, pin_oe;
   logic       irq;
   int         mismatches = 0;
   int         checks_done = 0;
   gpio_port i_gpio_port (.sys_clk(sys_clk), .rst_n(rst_n), .req(req), .rdata(rdata),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq));
   gpio_board i_gpio_board (.pin_out(pin_out), .pin_oe(pin_oe), .pulls(pulls), .pin_in(pin_in));
   initial forever #2.5 sys_clk = ~sys_clk;
   task chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task bus(input logic w, input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      req <= '{w, !w, a, d};
      @(posedge sys_clk);
      req <= '0;
   endtask
   // read data stands only in the cycle after the strobe
   task rd(input logic [3:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      #1 chk(rdata, e);
   endtask
   task t_strap;
      chk(pin_oe, 8'h00);
      rd(4'h2, 8'h3c);
      bus(1'b1, 4'h2, 8'h00);
      rd(4'h2, 8'h3c);
      $display("strap done");
   endtask
   task t_irq;
      rd(4'h3, 8'h3c);
      bus(1'b1, 4'h4, 8'h04);
      #1 chk({7'h00, irq}, 8'h01);
      rd(4'h4, 8'h04);
      bus(1'b1, 4'h4, 8'h00);
      #1 chk({7'h00, irq}, 8'h00);
      bus(1'b1, 4'h5, 8'hff);
      bus(1'b1, 4'h3, 8'hff);
      rd(4'h3, 8'h00);
      pulls <= 8'h3d;
      repeat (4) @(posedge sys_clk);
      rd(4'h3, 8'h01);
      rd(4'h5, 8'hff);
      bus(1'b1, 4'h5, 8'h00);
      bus(1'b1, 4'h6, 8'h01);
      bus(1'b1, 4'h3, 8'hff);
      rd(4'h3, 8'h3c);
      rd(4'h6, 8'h01);
      bus(1'b1, 4'h6, 8'h00);
      $display("irq done");
   endtask
   task t_dir;
      bus(1'b1, 4'h1, 8'h0f);
      bus(1'b1, 4'h0, 8'ha5);
      #1 chk(pin_oe, 8'h0f);
      chk(pin_out, 8'ha5);
      rd(4'h1, 8'h0f);
      rd(4'h0, 8'h35);
      bus(1'b1, 4'h1, 8'hff);
      rd(4'h0, 8'ha5);
      bus(1'b1, 4'h7, 8'h55);
      rd(4'h7, 8'h00);
      $display("dir done");
   endtask
   // mid-run reset: outputs released, strap taken again from the pulls
   task t_reset;
      pulls <= 8'hc3;
      @(posedge sys_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      #1 chk(pin_oe, 8'h00);
      chk(pin_out, 8'h00);
      rd(4'h2, 8'hc3);
      rd(4'h1, 8'h00);
      $display("reset done");
   endtask
   task close_out;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      #100000;
      mismatches++;
      close_out;
   end
   initial begin
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      t_strap;
      t_irq;
      t_dir;
      t_reset;
      close_out;
   end
endmodule // tb_gpio_port
